// >>> core/dfc_alarm_pin.sv
`timescale 1ns/10ps
module dfc_alarm_pin (
	input wire logic pclk,
	input wire logic presetn,
	dfc_ctl_if.sink ctl,
	input wire logic fault_active,
	output logic alarm_o,
	output logic alarm_oe
);
	logic alarm_r;
	logic alarm_nxt;
	logic oe_r;
	logic oe_nxt;

	always_comb begin
		alarm_nxt = ctl.alarm_polarity ? fault_active : ~fault_active;
		oe_nxt = ctl.alarm_out_enable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_r <= 1'b1;
			oe_r <= 1'b1;
		end else begin
			alarm_r <= alarm_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign alarm_o = alarm_r;
	assign alarm_oe = oe_r;
endmodule // dfc_alarm_pin

// >>> core/dfc_clkdiv_sync.sv
`timescale 1ns/10ps
module dfc_clkdiv_sync (
	input wire logic pclk,
	input wire logic presetn,
	dfc_ctl_if.sink ctl,
	input wire logic sync_pin,
	input wire logic soft_sync,
	input wire dfc_pkg::dfc_sync_src_t sync_src,
	output logic [3:0] div_en,
	output logic [3:0] phase,
	output logic sync_event
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;
	logic lvl_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [3:0] en_r;
	logic [3:0] en_nxt;
	logic ev_r;
	logic ev_nxt;
	logic pin_rise;

	always_comb begin
		lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
		pin_rise = lvl_nxt & ~lvl_r;
		ev_nxt = 1'b0;
		if (sync_src == dfc_pkg::DFC_SYNC_SRC_PIN) begin
			ev_nxt = pin_rise;
		end else if (sync_src == dfc_pkg::DFC_SYNC_SRC_SOFT) begin
			ev_nxt = soft_sync;
		end
		ev_nxt = ev_nxt & ctl.clkdiv_sync_enable;
		// restart all divided rates from a common phase
		cnt_nxt = ev_nxt ? dfc_pkg::DFC_PHASE_RESET : cnt_r + 4'h1;
		en_nxt[0] = cnt_nxt[0];
		en_nxt[1] = &cnt_nxt[1:0];
		en_nxt[2] = &cnt_nxt[2:0];
		en_nxt[3] = &cnt_nxt[3:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
			cnt_r <= dfc_pkg::DFC_PHASE_RESET;
			en_r <= 4'h0;
			ev_r <= 1'b0;
		end else begin
			s1_r <= sync_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
			cnt_r <= cnt_nxt;
			en_r <= en_nxt;
			ev_r <= ev_nxt;
		end
	end

	assign div_en = en_r;
	assign phase = cnt_r;
	assign sync_event = ev_r;
endmodule // dfc_clkdiv_sync

// >>> core/dfc_ctl_if.sv
`timescale 1ns/10ps
interface dfc_ctl_if;
	logic alarm_out_enable;
	logic alarm_polarity;
	logic clkdiv_sync_enable;

	modport ctl (
		output alarm_out_enable,
		output alarm_polarity,
		output clkdiv_sync_enable
	);
	modport sink (
		input alarm_out_enable,
		input alarm_polarity,
		input clkdiv_sync_enable
	);
endinterface

// >>> core/dfc_feature_ctrl.sv
// The APB slave port was decided locally.
`timescale 1ns/10ps
// Contract
// - bit 15 enables pair ab offset correction
// - bit 14 enables pair cd offset correction
// - bit 13 enables pair ab gain/phase correction
// - bit 12 enables pair cd gain/phase correction
// - bits 11:8 select interpolation, reset 8x
// - bit 7 routes samples through fifo
// - bit 4 drives fault pin, else high-z
// - bit 3 selects fault pin polarity
// - sync enable realigns divided clocks on sync
// - bit 1 enables pair ab inverse sinc
// - bit 0 enables pair cd inverse sinc
// - bits 6:5 reserved, zero, no effect
module dfc_feature_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fault_active,
	input wire logic sync_pin,
	input wire dfc_pkg::dfc_sync_src_t sync_src,
	output logic pair_ab_offset_corr_enable,
	output logic pair_cd_offset_corr_enable,
	output logic pair_ab_gain_phase_enable,
	output logic pair_cd_gain_phase_enable,
	output logic [3:0] rate_code,
	output logic [2:0] rate_log2,
	output logic fifo_enable,
	output logic pair_ab_sinc_comp_enable,
	output logic pair_cd_sinc_comp_enable,
	output logic alarm_o,
	output logic alarm_oe,
	output logic [3:0] div_en,
	output logic sync_event
);
	logic [15:0] ctrl_r;
	logic [15:0] ctrl_nxt;
	logic [2:0] log2_r;
	logic [2:0] log2_nxt;
	logic seen_r;
	logic seen_nxt;
	logic soft_r;
	logic soft_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic err_r;
	logic err_nxt;
	logic setup;
	logic wr_ctrl;
	logic wr_sync;
	logic [15:0] wdata;
	logic [15:0] lane_mask;
	logic [3:0] new_rate;
	logic rate_ok;
	logic [3:0] phase;
	logic sync_ev;

	dfc_ctl_if ctl_bus ();

	assign setup = psel & ~penable;
	assign wr_ctrl = psel & penable & pwrite & (paddr == dfc_pkg::DFC_ADDR_CTRL);
	assign wr_sync = psel & penable & pwrite & (paddr == dfc_pkg::DFC_ADDR_SYNC);
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// write path: byte lanes, reserved bits forced to zero, illegal rate kept
	always_comb begin
		wdata = (pwdata[15:0] & lane_mask) | (ctrl_r & ~lane_mask);
		new_rate = wdata[dfc_pkg::DFC_B_RATE_HI:dfc_pkg::DFC_B_RATE_LO];
		rate_ok = 1'b1;
		log2_nxt = log2_r;
		case (new_rate)
			dfc_pkg::DFC_RATE_X1: log2_nxt = 3'h0;
			dfc_pkg::DFC_RATE_X2: log2_nxt = 3'h1;
			dfc_pkg::DFC_RATE_X4: log2_nxt = 3'h2;
			dfc_pkg::DFC_RATE_X8: log2_nxt = 3'h3;
			dfc_pkg::DFC_RATE_X16: log2_nxt = 3'h4;
			default: rate_ok = 1'b0;
		endcase
		if (!rate_ok) begin
			wdata[dfc_pkg::DFC_B_RATE_HI:dfc_pkg::DFC_B_RATE_LO] =
				ctrl_r[dfc_pkg::DFC_B_RATE_HI:dfc_pkg::DFC_B_RATE_LO];
		end
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = wdata & dfc_pkg::DFC_CTRL_WMASK;
		end else begin
			log2_nxt = log2_r;
		end
	end

	// sync status: set by a sync event wins over a write-one clear
	always_comb begin
		seen_nxt = seen_r;
		soft_nxt = 1'b0;
		if (wr_sync && pstrb[0]) begin
			if (pwdata[dfc_pkg::DFC_B_SYNC_SEEN]) begin
				seen_nxt = 1'b0;
			end
			soft_nxt = pwdata[dfc_pkg::DFC_B_SYNC_SW];
		end
		if (sync_ev) begin
			seen_nxt = 1'b1;
		end
	end

	// read data and error are prepared in the setup cycle
	always_comb begin
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		if (setup) begin
			rdata_nxt = 32'h0000_0000;
			err_nxt = 1'b0;
			if (paddr == dfc_pkg::DFC_ADDR_CTRL) begin
				rdata_nxt[15:0] = ctrl_r;
			end else if (paddr == dfc_pkg::DFC_ADDR_SYNC) begin
				rdata_nxt[dfc_pkg::DFC_B_SYNC_SEEN] = seen_r;
				rdata_nxt[dfc_pkg::DFC_B_PHASE_LO +: 4] = phase;
			end else begin
				err_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= dfc_pkg::DFC_CTRL_RESET;
			log2_r <= dfc_pkg::DFC_RATE_LOG2_RESET;
			seen_r <= 1'b0;
			soft_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			log2_r <= log2_nxt;
			seen_r <= seen_nxt;
			soft_r <= soft_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign pready = 1'b1;
	assign prdata = rdata_r;
	assign pslverr = err_r & psel & penable;

	assign ctl_bus.alarm_out_enable = ctrl_r[dfc_pkg::DFC_B_ALM_OE];
	assign ctl_bus.alarm_polarity = ctrl_r[dfc_pkg::DFC_B_ALM_POL];
	assign ctl_bus.clkdiv_sync_enable = ctrl_r[dfc_pkg::DFC_B_DIV_SYNC];

	dfc_alarm_pin u_alarm (
		.pclk(pclk),
		.presetn(presetn),
		.ctl(ctl_bus.sink),
		.fault_active(fault_active),
		.alarm_o(alarm_o),
		.alarm_oe(alarm_oe)
	);

	dfc_clkdiv_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ctl(ctl_bus.sink),
		.sync_pin(sync_pin),
		.soft_sync(soft_r),
		.sync_src(sync_src),
		.div_en(div_en),
		.phase(phase),
		.sync_event(sync_ev)
	);

	assign sync_event = sync_ev;
	assign pair_ab_offset_corr_enable = ctrl_r[dfc_pkg::DFC_B_AB_OFS];
	assign pair_cd_offset_corr_enable = ctrl_r[dfc_pkg::DFC_B_CD_OFS];
	assign pair_ab_gain_phase_enable = ctrl_r[dfc_pkg::DFC_B_AB_GP];
	assign pair_cd_gain_phase_enable = ctrl_r[dfc_pkg::DFC_B_CD_GP];
	assign rate_code = ctrl_r[dfc_pkg::DFC_B_RATE_HI:dfc_pkg::DFC_B_RATE_LO];
	assign rate_log2 = log2_r;
	assign fifo_enable = ctrl_r[dfc_pkg::DFC_B_FIFO];
	assign pair_ab_sinc_comp_enable = ctrl_r[dfc_pkg::DFC_B_AB_SINC];
	assign pair_cd_sinc_comp_enable = ctrl_r[dfc_pkg::DFC_B_CD_SINC];
endmodule // dfc_feature_ctrl

// >>> core/dfc_pkg.sv
package dfc_pkg;
	// apb map, byte addresses
	localparam int unsigned DFC_AW = 12;
	localparam logic [11:0] DFC_ADDR_CTRL = 12'h000;
	localparam logic [11:0] DFC_ADDR_SYNC = 12'h004;

	// feature control register layout
	localparam int unsigned DFC_CTRL_W = 16;
	localparam logic [15:0] DFC_CTRL_RESET = 16'h049c;
	localparam logic [15:0] DFC_CTRL_WMASK = 16'hff9f;
	localparam int unsigned DFC_B_AB_OFS = 15;
	localparam int unsigned DFC_B_CD_OFS = 14;
	localparam int unsigned DFC_B_AB_GP = 13;
	localparam int unsigned DFC_B_CD_GP = 12;
	localparam int unsigned DFC_B_RATE_HI = 11;
	localparam int unsigned DFC_B_RATE_LO = 8;
	localparam int unsigned DFC_B_FIFO = 7;
	localparam int unsigned DFC_B_ALM_OE = 4;
	localparam int unsigned DFC_B_ALM_POL = 3;
	localparam int unsigned DFC_B_DIV_SYNC = 2;
	localparam int unsigned DFC_B_AB_SINC = 1;
	localparam int unsigned DFC_B_CD_SINC = 0;

	// rate multiplier codes
	localparam logic [3:0] DFC_RATE_X1 = 4'h0;
	localparam logic [3:0] DFC_RATE_X2 = 4'h1;
	localparam logic [3:0] DFC_RATE_X4 = 4'h2;
	localparam logic [3:0] DFC_RATE_X8 = 4'h4;
	localparam logic [3:0] DFC_RATE_X16 = 4'h8;
	localparam logic [2:0] DFC_RATE_LOG2_RESET = 3'h3;

	// sync control register layout
	localparam int unsigned DFC_B_SYNC_SEEN = 0;
	localparam int unsigned DFC_B_SYNC_SW = 1;
	localparam int unsigned DFC_B_PHASE_LO = 4;
	localparam int unsigned DFC_DIV_W = 4;
	localparam logic [3:0] DFC_PHASE_RESET = 4'h0;

	typedef enum logic [1:0] {
		DFC_SYNC_SRC_PIN,
		DFC_SYNC_SRC_SOFT,
		DFC_SYNC_SRC_OFF
	} dfc_sync_src_t;
endpackage

// >>> sim/dfc_feature_ctrl_monitor.sv
`timescale 1ns/10ps
module dfc_feature_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic fault_active,
	input wire logic pair_ab_offset_corr_enable,
	input wire logic [3:0] rate_code,
	input wire logic fifo_enable,
	input wire logic pair_ab_sinc_comp_enable,
	input wire logic alarm_o,
	input wire logic alarm_oe,
	input wire logic sync_event
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic acc, w0, w1;
	assign acc = psel && penable && paddr == 12'h000;
	assign w0 = acc && pwrite && pstrb[0];
	assign w1 = acc && pwrite && pstrb[1];
	ofs_ab_a: assert property (w1 |=> pair_ab_offset_corr_enable == $past(pwdata[15]))
		else $error("offset enable wrong");
	rate_sel_a: assert property (w1 |=> rate_code == ($onehot0($past(pwdata[11:8]))
		? $past(pwdata[11:8]) : $past(rate_code))) else $error("rate wrong");
	fifo_en_a: assert property (w0 |=> fifo_enable == $past(pwdata[7]))
		else $error("fifo enable wrong");
	pin_drive_a: assert property (w0 |-> ##2 alarm_oe == $past(pwdata[4], 2))
		else $error("pin drive wrong");
	pin_pol_a: assert property (w0 |-> ##2
		alarm_o == ($past(fault_active) ~^ $past(pwdata[3], 2))) else $error("polarity wrong");
	sinc_ab_a: assert property (w0 |=> pair_ab_sinc_comp_enable == $past(pwdata[1]))
		else $error("sinc enable wrong");
	resv_read_a: assert property (acc && !pwrite |-> prdata[6:5] == 2'b00)
		else $error("reserved bits read");
	field_hold_a: assert property (!(w0 || w1) |=> $stable(rate_code) && $stable(fifo_enable))
		else $error("field changed");
	cover property (w1 && pwdata[11:8] == 4'h3);
	cover property (sync_event);
	cover property (w0 && !pwdata[4]);
endmodule // dfc_feature_ctrl_monitor
bind dfc_feature_ctrl dfc_feature_ctrl_monitor mon (.*);

// >>> sim/dfc_feature_ctrl_test.sv
`timescale 1ns/10ps
module dfc_feature_ctrl_test;
	logic pclk, presetn, psel, penable, pwrite, fault_active, sync_pin, err;
	logic pready, pslverr, alarm_o, alarm_oe, sync_event, fifo_enable;
	logic pair_ab_offset_corr_enable, pair_cd_offset_corr_enable;
	logic pair_ab_gain_phase_enable, pair_cd_gain_phase_enable;
	logic pair_ab_sinc_comp_enable, pair_cd_sinc_comp_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb, rate_code, div_en;
	logic [2:0] rate_log2;
	logic [15:0] e;
	dfc_pkg::dfc_sync_src_t sync_src;
	logic [15:0] wv [7] = '{16'h8001, 16'h4102, 16'h2298, 16'h1460, 16'hf8ff, 16'h0316, 16'hffff};
	logic [3:0] ws [7] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h1};
	int fails, checked, nsync, i, since;
	dfc_feature_ctrl DUT (.*);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(negedge pclk) begin
		if (sync_event === 1'b1) begin
			nsync++;
			since = 0;
		end else begin
			since++;
		end
	end
	task automatic stop_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, x, g);
		end
	endtask
	// divided enables restart together after a sync pulse
	task automatic div_chk;
		int t;
		logic [3:0] x;
		t = -1;
		for (int c = 0; c < 24; c++) begin
			@(negedge pclk);
			t = (sync_event === 1'b1) ? 0 : ((t < 0) ? t : t + 1);
			if (t >= 0) begin
				for (int k = 0; k < 4; k++) begin
					x[k] = ((t + 1) % (2 << k)) == 0;
				end
				chk("div_en", {28'h0, x}, {28'h0, div_en});
			end
		end
		@(posedge pclk);
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fails++;
			stop_test();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [15:0] v, input logic [3:0] s);
		bus(1'b1, 12'h000, {16'h0000, v}, s);
		if (s[0]) e[7:0] = v[7:0] & 8'h9f;
		if (s[1]) e[15:8] = {v[15:12], $onehot0(v[11:8]) ? v[11:8] : e[11:8]};
	endtask
	task automatic look;
		bus(1'b0, 12'h000, 32'h0000_0000, 4'h0);
		chk("readback", {16'h0000, e}, q);
		chk("enables", {21'h0, e[15:7], e[1:0]}, {21'h0, pair_ab_offset_corr_enable,
			pair_cd_offset_corr_enable, pair_ab_gain_phase_enable, pair_cd_gain_phase_enable,
			rate_code, fifo_enable, pair_ab_sinc_comp_enable, pair_cd_sinc_comp_enable});
		chk("log2", (e[11:8] == 4'h0) ? 0 : 32'($clog2(e[11:8]) + 1), {29'h0, rate_log2});
		chk("alarm", {30'h0, e[4], e[3] ~^ fault_active}, {30'h0, alarm_oe, alarm_o});
	endtask
	initial begin
		{presetn, psel, penable, pwrite, fault_active, sync_pin} = 6'h00;
		{paddr, pwdata, pstrb} = '0;
		sync_src = dfc_pkg::DFC_SYNC_SRC_SOFT;
		e = 16'h049c;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		look;
		for (i = 0; i < 7; i++) begin
			fault_active <= i[0];
			wr(wv[i], ws[i]);
			look;
		end
		bus(1'b0, 12'h010, 32'h0000_0000, 4'h0);
		chk("slverr", 32'h0000_0001, {31'h0, err});
		chk("unmapped", 32'h0000_0000, q);
		bus(1'b1, 12'h010, 32'hffff_ffff, 4'hf);
		look;
		i = nsync;
		bus(1'b1, 12'h004, 32'h0000_0002, 4'hf);
		div_chk;
		chk("sync on", 32'(i + 1), 32'(nsync));
		bus(1'b0, 12'h004, 32'h0000_0000, 4'h0);
		chk("sync reg", {24'h0, 4'(since - 2), 4'h1}, q);
		bus(1'b1, 12'h004, 32'h0000_0001, 4'h1);
		bus(1'b0, 12'h004, 32'h0000_0000, 4'h0);
		chk("seen clear", 32'h0000_0000, {31'h0, q[0]});
		sync_src <= dfc_pkg::DFC_SYNC_SRC_PIN;
		sync_pin <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("pin sync", 32'(i + 2), 32'(nsync));
		sync_src <= dfc_pkg::DFC_SYNC_SRC_OFF;
		sync_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		sync_pin <= 1'b1;
		bus(1'b1, 12'h004, 32'h0000_0002, 4'hf);
		repeat (8) @(posedge pclk);
		chk("source off", 32'(i + 2), 32'(nsync));
		sync_src <= dfc_pkg::DFC_SYNC_SRC_SOFT;
		wr(16'h0000, 4'h3);
		bus(1'b1, 12'h004, 32'h0000_0002, 4'hf);
		repeat (4) @(posedge pclk);
		chk("sync off", 32'(i + 2), 32'(nsync));
		stop_test();
	end
endmodule // dfc_feature_ctrl_test
